// ===== src/vicirq_pkg.sv
`default_nettype none
package vicirq_pkg;
    // ***********************************************
    // sizes
    // ***********************************************
    localparam int unsigned VICIRQ_NUM_SRC = 32;
    localparam int unsigned VICIRQ_NUM_SLOT = 16;
    localparam int unsigned VICIRQ_SRC_W = 5;
    localparam int unsigned VICIRQ_SLOT_W = 4;
    localparam int unsigned VICIRQ_SOFT_CHAN = 1;

    // ***********************************************
    // register byte offsets
    // ***********************************************
    localparam logic [11:0] VICIRQ_OFS_FAST_STAT = 12'h000;
    localparam logic [11:0] VICIRQ_OFS_NORM_STAT = 12'h004;
    localparam logic [11:0] VICIRQ_OFS_RAW_STAT = 12'h008;
    localparam logic [11:0] VICIRQ_OFS_FAST_SEL = 12'h00c;
    localparam logic [11:0] VICIRQ_OFS_ENABLE = 12'h010;
    localparam logic [11:0] VICIRQ_OFS_ENA_CLR = 12'h014;
    localparam logic [11:0] VICIRQ_OFS_SOFT_SET = 12'h018;
    localparam logic [11:0] VICIRQ_OFS_SOFT_CLR = 12'h01c;
    localparam logic [11:0] VICIRQ_OFS_VEC_ADDR = 12'h030;
    localparam logic [11:0] VICIRQ_OFS_DEF_ADDR = 12'h034;
    localparam logic [11:0] VICIRQ_OFS_SLOT_ADDR = 12'h100;
    localparam logic [11:0] VICIRQ_OFS_SLOT_CTRL = 12'h200;
    localparam logic [11:0] VICIRQ_SLOT_SPAN = 12'h040;

    // ***********************************************
    // slot control fields
    // ***********************************************
    localparam int unsigned VICIRQ_SLOT_EN_BIT = 5;
    localparam logic [31:0] VICIRQ_RST_WORD = 32'h0000_0000;

    // ***********************************************
    // ahb-lite constants
    // ***********************************************
    localparam logic [1:0] VICIRQ_HTRANS_NONSEQ = 2'h2;
    localparam logic [1:0] VICIRQ_HTRANS_SEQ = 2'h3;

    typedef struct packed {
        logic en;
        logic [VICIRQ_SRC_W-1:0] src;
    } vicirq_slot_t;

    typedef struct packed {
        logic valid;
        logic write;
        logic [11:0] addr;
    } vicirq_acc_t;
endpackage
`default_nettype wire

// ===== src/vicirq_prio.sv
`default_nettype none
module vicirq_prio
    import vicirq_pkg::*;
#(
    parameter int unsigned N_SLOT = VICIRQ_NUM_SLOT,
    parameter int unsigned N_SRC = VICIRQ_NUM_SRC
)
(
    // slot settings and requests
    input wire vicirq_slot_t slot_cfg [N_SLOT],
    input wire logic [N_SRC-1:0] req_norm,
    // result
    output logic hit,
    output logic [VICIRQ_SLOT_W-1:0] slot_idx,
    output logic [N_SLOT-1:0] slot_act
)
;
    // ***********************************************
    // per-slot activity, lowest index wins
    // ***********************************************
    always_comb
    begin
        hit = 1'b0;
        slot_idx = '0;
        slot_act = '0;
        for (int i = N_SLOT - 1; i >= 0; i--)
        begin
            slot_act[i] = slot_cfg[i].en && req_norm[slot_cfg[i].src];
            if (slot_act[i])
            begin
                hit = 1'b1;
                slot_idx = VICIRQ_SLOT_W'(i);
            end
        end
    end
endmodule
`default_nettype wire

// ===== src/vicirq_ahb.sv
`default_nettype none
module vicirq_ahb
    import vicirq_pkg::*;
(
    // clock and reset
    input wire logic sys_clk,
    input wire logic arst_n,
    // ahb-lite slave side
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic hready,
    output logic hreadyout,
    output logic hresp,
    // decoded data phase
    output vicirq_acc_t acc
)
;
    // ***********************************************
    // address phase capture
    // ***********************************************
    wire logic take;
    vicirq_acc_t acc_ff;
    vicirq_acc_t nxt_acc;

    assign take = hsel && hready && (htrans == VICIRQ_HTRANS_NONSEQ || htrans == VICIRQ_HTRANS_SEQ);
    assign nxt_acc = '{valid: take, write: hwrite, addr: haddr[11:0]};
    assign hreadyout = 1'b1;
    assign hresp = 1'b0;
    assign acc = acc_ff;

    always_ff @(posedge sys_clk or negedge arst_n)
    begin
        if (!arst_n)
            acc_ff <= '0;
        else if (hready)
            acc_ff <= nxt_acc;
    end
endmodule
`default_nettype wire

// ===== src/vicirq_top.sv
`default_nettype none
module vicirq_top
    import vicirq_pkg::*;
#(
    parameter int unsigned N_SRC = VICIRQ_NUM_SRC,
    parameter int unsigned N_SLOT = VICIRQ_NUM_SLOT
)
(
    // clock and reset
    input wire logic sys_clk,
    input wire logic arst_n,
    // peripheral request lines
    input wire logic [N_SRC-1:0] periph_req,
    // ahb-lite slave
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic hresp,
    output logic [31:0] hrdata,
    // processor request outputs
    output logic fast_interrupt_request,
    output logic normal_irq
)
;
    // ***********************************************
    // request input synchroniser
    // ***********************************************
    logic [N_SRC-1:0] req_meta_ff;
    logic [N_SRC-1:0] req_sync_ff;

    always_ff @(posedge sys_clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            req_meta_ff <= '0;
            req_sync_ff <= '0;
        end
        else
        begin
            req_meta_ff <= periph_req;
            req_sync_ff <= req_meta_ff;
        end
    end

    // ***********************************************
    // bus slave
    // ***********************************************
    vicirq_acc_t acc;

    vicirq_ahb u_ahb (
        .sys_clk(sys_clk),
        .arst_n(arst_n),
        .hsel(hsel),
        .haddr(haddr),
        .htrans(htrans),
        .hwrite(hwrite),
        .hsize(hsize),
        .hready(hready),
        .hreadyout(hreadyout),
        .hresp(hresp),
        .acc(acc)
    );

    function automatic logic is_slot_reg(input logic [11:0] a, input logic [11:0] base);
        is_slot_reg = (a >= base) && (a < base + VICIRQ_SLOT_SPAN) && (a[1:0] == 2'h0);
    endfunction

    function automatic logic [VICIRQ_SLOT_W-1:0] slot_of(input logic [11:0] a);
        slot_of = a[VICIRQ_SLOT_W+1:2];
    endfunction

    wire logic wr;
    wire logic [11:0] wa;
    assign wr = acc.valid && acc.write;
    assign wa = acc.addr;

    // ***********************************************
    // software registers
    // ***********************************************
    logic [N_SRC-1:0] fast_sel_ff;
    logic [N_SRC-1:0] enable_ff;
    logic [N_SRC-1:0] soft_req_ff;
    logic [31:0] def_addr_ff;
    logic [31:0] slot_addr_ff [N_SLOT];
    vicirq_slot_t slot_cfg_ff [N_SLOT];
    logic [N_SRC-1:0] nxt_enable;
    logic [N_SRC-1:0] nxt_soft_req;

    always_comb
    begin
        nxt_enable = enable_ff;
        nxt_soft_req = soft_req_ff;
        if (wr && wa == VICIRQ_OFS_ENABLE)
            nxt_enable = enable_ff | hwdata[N_SRC-1:0];
        if (wr && wa == VICIRQ_OFS_ENA_CLR)
            nxt_enable = enable_ff & ~hwdata[N_SRC-1:0];
        if (wr && wa == VICIRQ_OFS_SOFT_SET)
            nxt_soft_req = soft_req_ff | hwdata[N_SRC-1:0];
        if (wr && wa == VICIRQ_OFS_SOFT_CLR)
            nxt_soft_req = soft_req_ff & ~hwdata[N_SRC-1:0];
    end

    always_ff @(posedge sys_clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            fast_sel_ff <= '0;
            enable_ff <= '0;
            soft_req_ff <= '0;
            def_addr_ff <= VICIRQ_RST_WORD;
        end
        else
        begin
            enable_ff <= nxt_enable;
            soft_req_ff <= nxt_soft_req;
            if (wr && wa == VICIRQ_OFS_FAST_SEL)
                fast_sel_ff <= hwdata[N_SRC-1:0];
            if (wr && wa == VICIRQ_OFS_DEF_ADDR)
                def_addr_ff <= hwdata;
        end
    end

    // slot address and control registers, rewritable at run time
    always_ff @(posedge sys_clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            for (int i = 0; i < N_SLOT; i++)
            begin
                slot_addr_ff[i] <= VICIRQ_RST_WORD;
                slot_cfg_ff[i] <= '0;
            end
        end
        else if (wr)
        begin
            if (is_slot_reg(wa, VICIRQ_OFS_SLOT_ADDR))
                slot_addr_ff[slot_of(wa)] <= hwdata;
            if (is_slot_reg(wa, VICIRQ_OFS_SLOT_CTRL))
                slot_cfg_ff[slot_of(wa)] <= vicirq_slot_t'(hwdata[VICIRQ_SLOT_EN_BIT:0]);
        end
    end

    // ***********************************************
    // classification
    // ***********************************************
    wire logic [N_SRC-1:0] hw_req;
    wire logic [N_SRC-1:0] raw_req;
    wire logic [N_SRC-1:0] act_req;
    wire logic [N_SRC-1:0] fast_act;
    wire logic [N_SRC-1:0] norm_act;
    logic [N_SRC-1:0] in_slot;
    wire logic [N_SRC-1:0] nonvec_act;
    wire logic vec_hit;
    wire logic [VICIRQ_SLOT_W-1:0] vec_idx;

    // channel 1 has no hardware source
    assign hw_req = req_sync_ff & ~(N_SRC'(1) << VICIRQ_SOFT_CHAN);
    assign raw_req = hw_req | soft_req_ff;
    assign act_req = raw_req & enable_ff;
    assign fast_act = act_req & fast_sel_ff;
    assign norm_act = act_req & ~fast_sel_ff;

    always_comb
    begin
        in_slot = '0;
        for (int i = 0; i < N_SLOT; i++)
            if (slot_cfg_ff[i].en)
                in_slot[slot_cfg_ff[i].src] = 1'b1;
    end

    assign nonvec_act = norm_act & ~in_slot;

    vicirq_prio #(
        .N_SLOT(N_SLOT),
        .N_SRC(N_SRC)
    ) u_prio (
        .slot_cfg(slot_cfg_ff),
        .req_norm(norm_act),
        .hit(vec_hit),
        .slot_idx(vec_idx),
        .slot_act()
    );

    // ***********************************************
    // processor outputs
    // ***********************************************
    logic fast_ff;
    logic norm_ff;

    always_ff @(posedge sys_clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            fast_ff <= 1'b0;
            norm_ff <= 1'b0;
        end
        else
        begin
            fast_ff <= |fast_act;
            norm_ff <= vec_hit || (|nonvec_act);
        end
    end

    assign fast_interrupt_request = fast_ff;
    assign normal_irq = norm_ff;

    // ***********************************************
    // read mux
    // ***********************************************
    wire logic [31:0] vec_word;
    logic [31:0] rd_word;
    logic [31:0] rdata_ff;
    logic rd_phase_ff;

    // slots beat non-vectored requests
    assign vec_word = vec_hit ? slot_addr_ff[vec_idx] : def_addr_ff;

    always_comb
    begin
        rd_word = '0;
        if (wa == VICIRQ_OFS_FAST_STAT)
            rd_word[N_SRC-1:0] = fast_act;
        else if (wa == VICIRQ_OFS_NORM_STAT)
            rd_word[N_SRC-1:0] = norm_act;
        else if (wa == VICIRQ_OFS_RAW_STAT)
            rd_word[N_SRC-1:0] = raw_req;
        else if (wa == VICIRQ_OFS_FAST_SEL)
            rd_word[N_SRC-1:0] = fast_sel_ff;
        else if (wa == VICIRQ_OFS_ENABLE)
            rd_word[N_SRC-1:0] = enable_ff;
        else if (wa == VICIRQ_OFS_SOFT_SET)
            rd_word[N_SRC-1:0] = soft_req_ff;
        else if (wa == VICIRQ_OFS_VEC_ADDR)
            rd_word = vec_word;
        else if (wa == VICIRQ_OFS_DEF_ADDR)
            rd_word = def_addr_ff;
        else if (is_slot_reg(wa, VICIRQ_OFS_SLOT_ADDR))
            rd_word = slot_addr_ff[slot_of(wa)];
        else if (is_slot_reg(wa, VICIRQ_OFS_SLOT_CTRL))
            rd_word[VICIRQ_SLOT_EN_BIT:0] = slot_cfg_ff[slot_of(wa)];
    end

    always_ff @(posedge sys_clk or negedge arst_n)
    begin
        if (!arst_n)
            rd_phase_ff <= 1'b0;
        else
            rd_phase_ff <= acc.valid && !acc.write;
    end

    always_ff @(posedge sys_clk or negedge arst_n)
    begin
        if (!arst_n)
            rdata_ff <= '0;
        else if (acc.valid && !acc.write)
            rdata_ff <= rd_word;
    end

    // data phase reads the live state combinationally so no wait state is needed
    assign hrdata = (acc.valid && !acc.write) ? rd_word : (rd_phase_ff ? rdata_ff : '0);
endmodule
`default_nettype wire

// ===== tb/vicirq_checker.sv
`default_nettype none
module vicirq_checker
    import vicirq_pkg::*;
#(
    parameter int unsigned N_SRC = VICIRQ_NUM_SRC
)
(
    // clock and reset
    input wire logic sys_clk,
    input wire logic arst_n,
    // requests and bus
    input wire logic [N_SRC-1:0] periph_req,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic hready,
    input wire logic hreadyout,
    input wire logic hresp,
    input wire logic [31:0] hrdata,
    // processor outputs
    input wire logic fast_interrupt_request,
    input wire logic normal_irq
);
    // ***********************************************
    // data phase and quiet tracking
    // ***********************************************
    localparam logic [N_SRC-1:0] HW_MASK = ~(N_SRC'(1) << VICIRQ_SOFT_CHAN);
    logic rd_ff;
    logic wr_ff;
    logic [11:0] ofs_ff;
    logic [N_SRC-1:0] s1_ff;
    logic [N_SRC-1:0] s2_ff;
    logic [2:0] quiet_ff;
    wire logic take = hsel && hready && htrans[1];
    wire logic req_chg = ((periph_req ^ s1_ff) & HW_MASK) != '0;
    wire logic [2:0] nxt_quiet = (wr_ff || req_chg) ? 3'h0 : quiet_ff + 3'(quiet_ff != 3'h7);
    wire logic rd_fast = rd_ff && ofs_ff == VICIRQ_OFS_FAST_STAT;
    wire logic rd_norm = rd_ff && ofs_ff == VICIRQ_OFS_NORM_STAT;
    wire logic rd_raw = rd_ff && ofs_ff == VICIRQ_OFS_RAW_STAT;
    always_ff @(posedge sys_clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            rd_ff <= 1'h0;
            wr_ff <= 1'h0;
            ofs_ff <= 12'h0;
            s1_ff <= '0;
            s2_ff <= '0;
            quiet_ff <= 3'h0;
        end
        else
        begin
            rd_ff <= take && !hwrite;
            wr_ff <= take && hwrite;
            ofs_ff <= haddr[11:0];
            s1_ff <= periph_req;
            s2_ff <= s1_ff;
            quiet_ff <= nxt_quiet;
        end
    end
    // ***********************************************
    // assertions
    // ***********************************************
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!arst_n);
    AST_READY_ZERO_WAIT: assert property (hreadyout == 1'h1)
        else $error("bus slave inserted a wait state");
    AST_RESP_OKAY: assert property (take |=> hresp == 1'h0)
        else $error("bus response not okay");
    AST_RESET_QUIET: assert property (!$past(arst_n) |-> !fast_interrupt_request && !normal_irq)
        else $error("request output high right after reset");
    AST_FAST_STEADY: assert property (quiet_ff >= 3'h4 |-> $stable(fast_interrupt_request))
        else $error("fast output moved with no cause");
    AST_NORM_STEADY: assert property (quiet_ff == 3'h7 |-> normal_irq == $past(normal_irq))
        else $error("normal output moved with no cause");
    AST_RAW_HAS_HW: assert property (rd_raw |-> (hrdata[N_SRC-1:0] & s2_ff & HW_MASK) == (s2_ff & HW_MASK))
        else $error("raw status lost an active hardware request");
    AST_FAST_MATCH: assert property (rd_fast |=> fast_interrupt_request == (|$past(hrdata)))
        else $error("fast output disagrees with fast status");
    AST_NORM_MATCH: assert property (rd_norm ##1 1'h1 |-> normal_irq == (|$past(hrdata)))
        else $error("normal output disagrees with normal status");
    COV_FAST: cover property ($rose(fast_interrupt_request));
    COV_NORM: cover property ($rose(normal_irq) && !fast_interrupt_request);
    COV_VEC: cover property (rd_ff && ofs_ff == VICIRQ_OFS_VEC_ADDR);
endmodule
`default_nettype wire

// ===== tb/vicirq_core_model.sv
`default_nettype none
module vicirq_core_model
    import vicirq_pkg::*;
(
    // clock and reset
    input wire logic sys_clk,
    input wire logic arst_n,
    // request levels from the controller
    input wire logic fast_in,
    input wire logic norm_in,
    // handler entries taken
    output logic [7:0] fast_entries,
    output logic [7:0] norm_entries
);
    logic fast_ff;
    logic norm_ff;
    logic [7:0] fcnt_ff;
    logic [7:0] ncnt_ff;
    // fast entry wins over a normal entry in the same cycle
    always_ff @(posedge sys_clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            fast_ff <= 1'h0;
            norm_ff <= 1'h0;
            fcnt_ff <= 8'h0;
            ncnt_ff <= 8'h0;
        end
        else
        begin
            fast_ff <= fast_in;
            norm_ff <= norm_in;
            fcnt_ff <= fcnt_ff + 8'(fast_in && !fast_ff);
            ncnt_ff <= ncnt_ff + 8'(norm_in && !norm_ff && !fast_in);
        end
    end
    assign fast_entries = fcnt_ff;
    assign norm_entries = ncnt_ff;
endmodule
`default_nettype wire

// ===== tb/tb_vectored_interrupt_controller.sv
`default_nettype none
module tb_vectored_interrupt_controller
    import vicirq_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;
    typedef struct {logic [31:0] fsel; logic [31:0] en; logic [31:0] req; logic fast; logic norm;} vicirq_row_t;
    localparam logic [31:0] DEF_VEC = 32'h0000_0ff0;
    localparam logic [31:0] ALL = 32'hffff_ffff;
    logic sys_clk = 1'h0;
    logic arst_n;
    logic [31:0] periph_req;
    logic hsel;
    logic [31:0] haddr;
    logic [1:0] htrans;
    logic hwrite;
    logic [2:0] hsize;
    logic [31:0] hwdata;
    wire logic hready;
    wire logic hreadyout;
    wire logic hresp;
    wire logic [31:0] hrdata;
    wire logic fast_interrupt_request;
    wire logic normal_irq;
    wire logic [7:0] fast_entries;
    wire logic [7:0] norm_entries;
    int num_errors = 0;
    int samples_checked = 0;
    logic [31:0] act;
    vicirq_row_t rows [10] = '{
        '{32'h0, ALL, 32'h0010_0000, 1'h0, 1'h1}, '{32'h0, ALL, 32'h0010_0040, 1'h0, 1'h1},
        '{32'h0, ALL, 32'h0000_0440, 1'h0, 1'h1}, '{32'h0010_0000, ALL, 32'h0010_0040, 1'h1, 1'h1},
        '{32'h0, ALL, 32'h0000_0020, 1'h0, 1'h1}, '{32'h0, ALL, 32'h0000_0004, 1'h0, 1'h1},
        '{32'h0, ALL, 32'h0000_0002, 1'h0, 1'h0}, '{32'h0, 32'hffef_ffff, 32'h0010_0000, 1'h0, 1'h0},
        '{ALL, ALL, 32'h0200_0008, 1'h1, 1'h0}, '{32'h0, ALL, 32'h0, 1'h0, 1'h0}};
    assign hready = hreadyout;
    always #50 sys_clk = ~sys_clk;
    vicirq_top vicirq_top_i (.sys_clk(sys_clk), .arst_n(arst_n), .periph_req(periph_req), .hsel(hsel),
        .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
        .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .fast_interrupt_request(fast_interrupt_request),
        .normal_irq(normal_irq));
    vicirq_core_model vicirq_core_model_i (.sys_clk(sys_clk), .arst_n(arst_n), .fast_in(fast_interrupt_request),
        .norm_in(normal_irq), .fast_entries(fast_entries), .norm_entries(norm_entries));
    // ***********************************************
    // bus and check tasks
    // ***********************************************
    task automatic complete_run();
        $display("checks %0d mismatches %0d", samples_checked, num_errors);
        if (num_errors == 0 && samples_checked > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask
    task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
        samples_checked++;
        if (got !== exp)
        begin
            $display("Error %s expected %h seen %h", name, exp, got);
            num_errors++;
        end
    endtask
    task automatic wait_ready();
        int n;
        n = 0;
        @(posedge sys_clk);
        while (hready !== 1'h1)
        begin
            if (n == 50)
            begin
                num_errors++;
                complete_run();
            end
            n++;
            @(posedge sys_clk);
        end
    endtask
    task automatic ahb(input logic w, input logic [11:0] a, input logic [31:0] wd, output logic [31:0] rd);
        hsel <= 1'h1;
        htrans <= VICIRQ_HTRANS_NONSEQ;
        haddr <= {20'h0, a};
        hwrite <= w;
        wait_ready();
        hsel <= 1'h0;
        htrans <= 2'h0;
        hwdata <= wd;
        wait_ready();
        rd = hrdata;
    endtask
    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        logic [31:0] v;
        ahb(1'h1, a, d, v);
    endtask
    task automatic rd(input string name, input logic [11:0] a, input logic [31:0] exp);
        logic [31:0] v;
        ahb(1'h0, a, 32'h0, v);
        chk(name, exp, v);
    endtask
    function automatic logic [31:0] exp_vec(input logic [31:0] a);
        logic [31:0] v;
        v = DEF_VEC;
        for (int n = 14; n >= 0; n--)
            if (a[20-n])
                v = 32'h0000_1000 + 32'(n << 4);
        return v;
    endfunction
    // ***********************************************
    // main sequence
    // ***********************************************
    initial
    begin
        arst_n <= 1'h0;
        periph_req <= 32'h0;
        hsel <= 1'h0;
        haddr <= 32'h0;
        htrans <= 2'h0;
        hwrite <= 1'h0;
        hsize <= 3'h2;
        hwdata <= 32'h0;
        repeat (6) @(posedge sys_clk);
        arst_n <= 1'h1;
        @(posedge sys_clk);
        chk("fast_out", 32'h0, 32'(fast_interrupt_request));
        rd("fast_sel", VICIRQ_OFS_FAST_SEL, 32'h0);
        rd("enable", VICIRQ_OFS_ENABLE, 32'h0);
        rd("vec_addr", VICIRQ_OFS_VEC_ADDR, 32'h0);
        $display("test reset done");
        for (int n = 0; n < 16; n++)
        begin
            wr(VICIRQ_OFS_SLOT_ADDR + 12'(4 * n), 32'h0000_1000 + 32'(n << 4));
            wr(VICIRQ_OFS_SLOT_CTRL + 12'(4 * n), {26'h0, n != 15, 5'(20 - n)});
        end
        wr(VICIRQ_OFS_DEF_ADDR, DEF_VEC);
        foreach (rows[i])
        begin
            wr(VICIRQ_OFS_ENA_CLR, ALL);
            wr(VICIRQ_OFS_FAST_SEL, rows[i].fsel);
            wr(VICIRQ_OFS_ENABLE, rows[i].en);
            periph_req <= rows[i].req;
            repeat (4) @(posedge sys_clk);
            act = rows[i].req & rows[i].en & 32'hffff_fffd;
            chk("fast_out", 32'(rows[i].fast), 32'(fast_interrupt_request));
            chk("norm_out", 32'(rows[i].norm), 32'(normal_irq));
            rd("raw_stat", VICIRQ_OFS_RAW_STAT, rows[i].req & 32'hffff_fffd);
            rd("fast_stat", VICIRQ_OFS_FAST_STAT, act & rows[i].fsel);
            rd("norm_stat", VICIRQ_OFS_NORM_STAT, act & ~rows[i].fsel);
            rd("vec_addr", VICIRQ_OFS_VEC_ADDR, exp_vec(act & ~rows[i].fsel));
            $display("test row %0d done", i);
        end
        wr(VICIRQ_OFS_ENABLE, 32'h2);
        wr(VICIRQ_OFS_SOFT_SET, 32'h2);
        repeat (2) @(posedge sys_clk);
        chk("norm_out", 32'h1, 32'(normal_irq));
        rd("norm_stat", VICIRQ_OFS_NORM_STAT, 32'h2);
        wr(VICIRQ_OFS_FAST_SEL, 32'h2);
        repeat (2) @(posedge sys_clk);
        chk("fast_out", 32'h1, 32'(fast_interrupt_request));
        wr(VICIRQ_OFS_SOFT_CLR, 32'h2);
        repeat (2) @(posedge sys_clk);
        chk("fast_out", 32'h0, 32'(fast_interrupt_request));
        $display("test soft channel done");
        wr(12'h020, ALL);
        rd("unmapped", 12'h020, 32'h0);
        wr(VICIRQ_OFS_RAW_STAT, ALL);
        rd("raw_stat", VICIRQ_OFS_RAW_STAT, 32'h0);
        $display("test bus refusal done");
        chk("core_fast", 32'h1, 32'(fast_entries != 8'h0));
        chk("core_norm", 32'h1, 32'(norm_entries != 8'h0));
        arst_n <= 1'h0;
        @(posedge sys_clk);
        arst_n <= 1'h1;
        @(posedge sys_clk);
        rd("enable", VICIRQ_OFS_ENABLE, 32'h0);
        $display("test mid reset done");
        complete_run();
    end
endmodule
bind vicirq_top vicirq_checker #(.N_SRC(N_SRC)) vicirq_checker_i (.sys_clk, .arst_n, .periph_req, .hsel, .haddr,
    .htrans, .hwrite, .hready, .hreadyout, .hresp, .hrdata, .fast_interrupt_request, .normal_irq);
`default_nettype wire
